// [clw_defines.vh]
// Constants for the clock lock, wake-up and time base block
`ifndef CLW_DEFINES_VH
`define CLW_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CLW_OFS_CTRL      5'h00
`define CLW_OFS_LOCK      5'h04
`define CLW_OFS_TB_HI     5'h08
`define CLW_OFS_TB_LO     5'h0c
`define CLW_OFS_DEC       5'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CLW_CTL_LPMM      28
`define CLW_CTL_TBS       27
`define CLW_CTL_DCE       26
`define CLW_CTL_LOCK_LOSS_RESET_ENABLE     25
`define CLW_CTL_OSC_LOSS_RESET_ENABLE     24
`define CLW_CTL_MF_HI     22
`define CLW_CTL_MF_LO     19
`define CLW_CTL_LPM_HI    9
`define CLW_CTL_LPM_LO    8
`define CLW_CTL_RFD_HI    3
`define CLW_CTL_RFD_LO    0

// ----------------------------------------------------------------
// Lock and status register fields
// ----------------------------------------------------------------
`define CLW_LCK_MPL       0
`define CLW_LCK_POWER_MODE_LOCK      1
`define CLW_LCK_DIVIDER_LOCK      2
`define CLW_LCK_WUR       3
`define CLW_LCK_PLL_LOCKED_STATUS      4
`define CLW_LCK_PLL_LOCK_STICKY     5
`define CLW_LCK_LOO       6

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define CLW_RST_MF        4'h2
`define CLW_RST_LPM       2'h0
`define CLW_RST_RFD       4'h3
`define CLW_RST_DCE       1'b1
`define CLW_DEC_INIT      32'hffffffff
`define CLW_LPM_SLEEP     2'h3
`define CLW_SRC_DIV       2'h3

`endif

// [clw_top.v]
// Clock lock bits, wake-up output, time base and decrementer
`timescale 1ns/10ps
`default_nettype none
`include "clw_defines.vh"

module clw_top
(
   // Clock and reset
   input  wire        mclk_i,
   input  wire        rstn_i,
   // Register port
   input  wire [4:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output wire [31:0] rdata_o,
   // Pins from outside this clock domain
   input  wire        crystal_input_i,
   input  wire        pll_lock_i,
   input  wire        osc_lost_i,
   // Same-domain controls
   input  wire        freeze_i,
   input  wire        freeze_counter_enable_i,
   input  wire        special_test_i,
   input  wire        pll_bypass_i,
   input  wire        external_interrupt_enable_i,
   // Outputs
   output wire        wakeup_out_o,
   output wire        dec_irq_o,
   output wire        clock_reset_o,
   output wire [3:0]  multiplication_factor_o,
   output wire [1:0]  low_power_select_o,
   output wire [3:0]  reduced_divider_o,
   output wire        counter_source_select_o,
   output wire        self_clocked_mode_o
);

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   reg        rst_meta_ff;
   reg        rst_sync_ff;
   reg [2:0]  pin_meta_ff;
   reg [2:0]  pin_sync_ff;
   reg        xtal_prev_ff;

   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   always @(posedge mclk_i)
   begin
      pin_meta_ff  <= {osc_lost_i, pll_lock_i, crystal_input_i};
      pin_sync_ff  <= pin_meta_ff;
      xtal_prev_ff <= pin_sync_ff[0];
   end

   // Crystal edges are counted only after both sync stages
   wire xtal_rise = pin_sync_ff[0] & ~xtal_prev_ff;

   // Released copy: asserts at once with the pin, leaves on a clock
   // edge, so no flop sees reset end part way through a cycle
   wire rst_n = rst_sync_ff;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   reg        lpmm_ff;
   reg        tbs_ff;
   reg        dce_ff;
   reg        lock_loss_reset_enable_ff;
   reg        osc_loss_reset_enable_ff;
   reg [3:0]  mf_ff;
   reg [1:0]  lpm_ff;
   reg [3:0]  rfd_ff;
   reg        mpl_ff;
   reg        power_mode_lock_ff;
   reg        divider_lock_ff;
   reg        sticky_ff;
   reg        test_loo_ff;
   reg [31:0] rdata_ff;

   // ----------------------------------------------------------------
   // Keep-alive state: no reset by design
   // ----------------------------------------------------------------
   // Held over every reset; only a supply loss upsets them
   reg        wur_ff;
   reg [63:0] tb_ff;
   reg [31:0] dec_ff;
   reg        dce_eff_ff;
   reg [1:0]  div_ff;
   reg        irq_ff;

   // Simulation start only; after supply loss these are undefined
   initial
   begin
      dec_ff     = `CLW_DEC_INIT;
      wur_ff     = 1'b0;
      tb_ff      = 64'h0;
      dce_eff_ff = `CLW_RST_DCE;
      div_ff     = 2'h0;
      irq_ff     = 1'b0;
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // Exact decode, so unmapped offsets write nothing
   wire wr_ctrl  = wr_i & (addr_i == `CLW_OFS_CTRL);
   wire wr_lock  = wr_i & (addr_i == `CLW_OFS_LOCK);
   wire wr_tb_hi = wr_i & (addr_i == `CLW_OFS_TB_HI);
   wire wr_tb_lo = wr_i & (addr_i == `CLW_OFS_TB_LO);
   wire wr_dec   = wr_i & (addr_i == `CLW_OFS_DEC);

   // ----------------------------------------------------------------
   // Live status and clock reset
   // ----------------------------------------------------------------
   // Bypass and test mode report lock; the PLL is off there
   wire locked = pll_bypass_i | special_test_i | pin_sync_ff[1];
   wire osc_lost_status    = special_test_i ? test_loo_ff : pin_sync_ff[2];

   // Combined so a lost oscillator also drops lock
   wire unlocked = ~locked | osc_lost_status;

   wire clk_rst = ~rst_sync_ff
                | (lock_loss_reset_enable_ff & unlocked)
                | (osc_loss_reset_enable_ff & osc_lost_status);

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lpmm_ff  <= 1'b0;
         tbs_ff   <= 1'b0;
         dce_ff   <= `CLW_RST_DCE;
         lock_loss_reset_enable_ff <= 1'b0;
         osc_loss_reset_enable_ff <= 1'b0;
         mf_ff    <= `CLW_RST_MF;
         lpm_ff   <= `CLW_RST_LPM;
         rfd_ff   <= `CLW_RST_RFD;
      end
      else if (clk_rst)
      begin
         lpmm_ff  <= 1'b0;
         tbs_ff   <= 1'b0;
         dce_ff   <= `CLW_RST_DCE;
         lock_loss_reset_enable_ff <= 1'b0;
         osc_loss_reset_enable_ff <= 1'b0;
         mf_ff    <= `CLW_RST_MF;
         lpm_ff   <= `CLW_RST_LPM;
         rfd_ff   <= `CLW_RST_RFD;
      end
      else if (wr_ctrl)
      begin
         lpmm_ff  <= wdata_i[`CLW_CTL_LPMM];
         tbs_ff   <= wdata_i[`CLW_CTL_TBS];
         dce_ff   <= wdata_i[`CLW_CTL_DCE];
         lock_loss_reset_enable_ff <= wdata_i[`CLW_CTL_LOCK_LOSS_RESET_ENABLE];
         osc_loss_reset_enable_ff <= wdata_i[`CLW_CTL_OSC_LOSS_RESET_ENABLE];
         if (!mpl_ff)
            mf_ff <= wdata_i[`CLW_CTL_MF_HI:`CLW_CTL_MF_LO];
         if (!power_mode_lock_ff)
            lpm_ff <= wdata_i[`CLW_CTL_LPM_HI:`CLW_CTL_LPM_LO];
         if (!divider_lock_ff)
            rfd_ff <= wdata_i[`CLW_CTL_RFD_HI:`CLW_CTL_RFD_LO];
      end
   end

   // ----------------------------------------------------------------
   // Lock and status register
   // ----------------------------------------------------------------
   wire [2:0] lock_cur = {divider_lock_ff, power_mode_lock_ff, mpl_ff};
   wire [2:0] nxt_lock;

   // One cell per lock bit; positions run up from the first lock
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_lock
         wire wr_bit = wdata_i[`CLW_LCK_MPL + g];
         // Freeze takes any value; otherwise a zero cannot undo a one
         assign nxt_lock[g] = freeze_i ? wr_bit
                                       : lock_cur[g] | wr_bit;
      end
   endgenerate

   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mpl_ff       <= 1'b0;
         power_mode_lock_ff      <= 1'b0;
         divider_lock_ff      <= 1'b0;
         sticky_ff    <= 1'b0;
         test_loo_ff  <= 1'b0;
      end
      else if (clk_rst)
      begin
         mpl_ff       <= 1'b0;
         power_mode_lock_ff      <= 1'b0;
         divider_lock_ff      <= 1'b0;
         sticky_ff    <= 1'b0;
         test_loo_ff  <= 1'b0;
      end
      else
      begin
         if (wr_lock)
         begin
            mpl_ff  <= nxt_lock[0];
            power_mode_lock_ff <= nxt_lock[1];
            divider_lock_ff <= nxt_lock[2];
            if (special_test_i)
            begin
               // Lock status is forced high here, so only loss is kept
               test_loo_ff  <= wdata_i[`CLW_LCK_LOO];
            end
         end
         // Unlock beats a setting write in the same cycle
         if (unlocked)
            sticky_ff <= 1'b0;
         else if (wr_lock && wdata_i[`CLW_LCK_PLL_LOCK_STICKY])
            sticky_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Counter tick: source select, divide by four, sleep and freeze
   // ----------------------------------------------------------------
   // Freeze gates on the rising edge: one clock keeps the gate
   // free of falling-edge flops
   wire src_edge = tbs_ff ? 1'b1 : xtal_rise;
   wire halted   = (lpm_ff == `CLW_LPM_SLEEP)
                 | (freeze_i & freeze_counter_enable_i);
   wire tick     = src_edge & (div_ff == `CLW_SRC_DIV) & ~halted;

   always @(posedge mclk_i)
   begin
      if (src_edge && !halted)
         div_ff <= div_ff + 2'h1;
   end

   // ----------------------------------------------------------------
   // Time base, decrementer, wake-up request
   // ----------------------------------------------------------------
   wire        dec_step = tick & dce_eff_ff;
   wire [31:0] nxt_dec  = wr_dec ? wdata_i
                        : dec_step ? dec_ff - 32'h1 : dec_ff;
   // A written top bit over a clear one also wakes the supply
   wire        msb_rise = ~dec_ff[31] & nxt_dec[31];
   wire        wrap     = dec_step & (dec_ff == 32'h0);

   // Hi and lo words are read apart; software re-reads hi for a carry
   // None of these see any reset
   always @(posedge mclk_i)
   begin
      if (tick)
         dce_eff_ff <= dce_ff;
      dec_ff <= nxt_dec;
      if (wr_tb_hi)
         tb_ff[63:32] <= wdata_i;
      else if (wr_tb_lo)
         tb_ff[31:0] <= wdata_i;
      else if (tick)
         tb_ff <= tb_ff + 64'h1;
      // Hardware set wins over a clearing write
      if (msb_rise)
         wur_ff <= 1'b1;
      else if (wr_lock)
         wur_ff <= wdata_i[`CLW_LCK_WUR];
      irq_ff <= wrap & external_interrupt_enable_i;
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   reg [31:0] rd_mux;

   always @*
   begin
      rd_mux = 32'h0;
      case (addr_i)
         `CLW_OFS_CTRL:
         begin
            rd_mux[`CLW_CTL_LPMM]  = lpmm_ff;
            rd_mux[`CLW_CTL_TBS]   = tbs_ff;
            rd_mux[`CLW_CTL_DCE]   = dce_ff;
            rd_mux[`CLW_CTL_LOCK_LOSS_RESET_ENABLE] = lock_loss_reset_enable_ff;
            rd_mux[`CLW_CTL_OSC_LOSS_RESET_ENABLE] = osc_loss_reset_enable_ff;
            rd_mux[`CLW_CTL_MF_HI:`CLW_CTL_MF_LO]   = mf_ff;
            rd_mux[`CLW_CTL_LPM_HI:`CLW_CTL_LPM_LO] = lpm_ff;
            rd_mux[`CLW_CTL_RFD_HI:`CLW_CTL_RFD_LO] = rfd_ff;
         end
         `CLW_OFS_LOCK:
         begin
            rd_mux[`CLW_LCK_MPL]   = mpl_ff;
            rd_mux[`CLW_LCK_POWER_MODE_LOCK]  = power_mode_lock_ff;
            rd_mux[`CLW_LCK_DIVIDER_LOCK]  = divider_lock_ff;
            rd_mux[`CLW_LCK_WUR]   = wur_ff;
            rd_mux[`CLW_LCK_PLL_LOCKED_STATUS]  = locked & ~osc_lost_status;
            rd_mux[`CLW_LCK_PLL_LOCK_STICKY] = sticky_ff;
            rd_mux[`CLW_LCK_LOO]   = osc_lost_status;
         end
         `CLW_OFS_TB_HI: rd_mux = tb_ff[63:32];
         `CLW_OFS_TB_LO: rd_mux = tb_ff[31:0];
         `CLW_OFS_DEC:   rd_mux = dec_ff;
         default:        rd_mux = 32'h0;
      endcase
   end

   // Data valid only in the cycle after the strobe
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         rdata_ff <= 32'h0;
      else if (rd_i)
         rdata_ff <= rd_mux;
      else
         rdata_ff <= 32'h0;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Clock reset and loss status are live levels, not registered
   assign rdata_o                 = rdata_ff;
   assign wakeup_out_o            = wur_ff;
   assign dec_irq_o               = irq_ff;
   assign clock_reset_o           = clk_rst;
   assign multiplication_factor_o = mf_ff;
   assign low_power_select_o      = lpm_ff;
   assign reduced_divider_o       = rfd_ff;
   assign counter_source_select_o = tbs_ff;
   assign self_clocked_mode_o     = osc_lost_status;

endmodule
`default_nettype wire

// [clw_chk.sv]
// Checker for the clock lock, wake-up and time base block
`timescale 1ns/10ps
`default_nettype none
`include "clw_defines.vh"
module clw_chk
(
   // Clock, reset and register port
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic [4:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   // Pins and controls
   input wire logic        pll_lock_i,
   input wire logic        osc_lost_i,
   input wire logic        special_test_i,
   input wire logic        external_interrupt_enable_i,
   // Outputs under watch
   input wire logic        wakeup_out_o,
   input wire logic        dec_irq_o,
   input wire logic        clock_reset_o,
   input wire logic [3:0]  multiplication_factor_o,
   input wire logic [1:0]  low_power_select_o,
   input wire logic [3:0]  reduced_divider_o,
   input wire logic        counter_source_select_o,
   input wire logic        self_clocked_mode_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);
   // ----------------------------------------
   // Reset release and a quiet spell
   // ----------------------------------------
   sequence s_release;
      clock_reset_o [*2] ##1 !clock_reset_o;
   endsequence
   sequence s_calm;
      (rstn_i && pll_lock_i && !osc_lost_i) [*4];
   endsequence
   AST_WAKE_BY_WRAP: assert property (dec_irq_o |-> wakeup_out_o)
      else $error("wake pin low beside a decrementer wrap");
   AST_WAKE_SET: assert property (!clock_reset_o && wr_i &&
      addr_i == `CLW_OFS_LOCK && wdata_i[`CLW_LCK_WUR] |=> wakeup_out_o)
      else $error("wake pin not set by write");
   AST_IRQ_MASKED: assert property (!external_interrupt_enable_i &&
      !$past(external_interrupt_enable_i) |-> !dec_irq_o)
      else $error("masked decrementer interrupt seen");
   AST_IRQ_PULSE: assert property (dec_irq_o |=> !dec_irq_o)
      else $error("decrementer interrupt longer than one cycle");
   AST_RESET_RELEASE: assert property ($rose(rstn_i) |-> s_release)
      else $error("clock reset release timing wrong");
   AST_FIELDS_CLEAR: assert property (clock_reset_o |=>
      multiplication_factor_o == `CLW_RST_MF &&
      reduced_divider_o == `CLW_RST_RFD &&
      low_power_select_o == `CLW_RST_LPM && !counter_source_select_o)
      else $error("control fields not cleared by clock reset");
   AST_CALM_NO_RESET: assert property (s_calm |-> !clock_reset_o)
      else $error("clock reset without a cause");
   AST_OSC_FOLLOW: assert property ((!special_test_i &&
      osc_lost_i == $past(osc_lost_i)) [*3] |->
      self_clocked_mode_o == osc_lost_i)
      else $error("self-clocked output does not follow oscillator loss");
endmodule
bind clw_top clw_chk u_chk
(
   .mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .pll_lock_i, .osc_lost_i,
   .special_test_i, .external_interrupt_enable_i, .wakeup_out_o,
   .dec_irq_o, .clock_reset_o, .multiplication_factor_o,
   .low_power_select_o, .reduced_divider_o, .counter_source_select_o,
   .self_clocked_mode_o
);
`default_nettype wire

// [clw_partner.sv]
// Model of the crystal, oscillator monitor and PLL beside the block
`timescale 1ns/10ps
`default_nettype none
module clw_partner
(
   // Scenario commands from the bench
   input  wire logic drop_lock_i,
   input  wire logic drop_osc_i,
   // Pins toward the block
   output var logic  crystal_o,
   output wire logic lock_o,
   output wire logic lost_o
);
   // ----------------------------------------
   // Crystal; odd period keeps it off mclk rising edges
   // ----------------------------------------
   initial crystal_o = 1'b0;
   always #103 if (!drop_osc_i) crystal_o = ~crystal_o;
   // A dead oscillator also drops lock
   assign lost_o = drop_osc_i;
   assign lock_o = !(drop_lock_i || drop_osc_i);
endmodule
`default_nettype wire

// [clock_lock_wakeup_timebase_bench.sv]
// Self-checking bench for the clock lock, wake-up and time base block
`timescale 1ns/10ps
`default_nettype none
`include "clw_defines.vh"
module clock_lock_wakeup_timebase_bench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        mclk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [4:0]  addr_i = 5'h00;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        freeze_i = 1'b0;
   logic        freeze_counter_enable_i = 1'b0;
   logic        pll_bypass_i = 1'b0;
   logic        special_test_i = 1'b0;
   logic        external_interrupt_enable_i = 1'b1;
   logic [1:0]  drop = 2'h0;
   wire  [31:0] rdata;
   wire  [3:0]  mult, div;
   wire  [1:0]  pmode;
   wire         xtal, lock, lost, wake, irq, crst, src, selfclk;
   int          mismatches = 0;
   int          check_count = 0;
   int          cycles = 0;
   logic [31:0] v, w;
   logic [22:0] r;
   bit          hit;
   logic [3:0]  fsel [4] = '{4'hc, 4'hc, 4'he, 4'hd};
   // Lock bits, fields written, fields expected
   logic [22:0] rows [5] = '{{3'h0, 4'h5, 2'h1, 4'h7, 4'h5, 2'h1, 4'h7},
      {3'h1, 4'h9, 2'h2, 4'h1, 4'h5, 2'h2, 4'h1},
      {3'h2, 4'h3, 2'h0, 4'h4, 4'h3, 2'h2, 4'h4},
      {3'h4, 4'h6, 2'h1, 4'h0, 4'h6, 2'h1, 4'h4},
      {3'h7, 4'h1, 2'h0, 4'h9, 4'h6, 2'h1, 4'h4}};
   clw_top u_clw_top
   (
      .mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o(rdata),
      .crystal_input_i(xtal), .pll_lock_i(lock), .osc_lost_i(lost),
      .freeze_i, .freeze_counter_enable_i, .special_test_i,
      .pll_bypass_i, .external_interrupt_enable_i, .wakeup_out_o(wake),
      .dec_irq_o(irq), .clock_reset_o(crst),
      .multiplication_factor_o(mult), .low_power_select_o(pmode),
      .reduced_divider_o(div), .counter_source_select_o(src),
      .self_clocked_mode_o(selfclk)
   );
   clw_partner u_clw_partner
   (
      .drop_lock_i(drop[0]), .drop_osc_i(drop[1]), .crystal_o(xtal),
      .lock_o(lock), .lost_o(lost)
   );
   initial forever #12.5 mclk_i = ~mclk_i;
   // ----------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      d = rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   function automatic logic [31:0] ctl(input logic [3:0] mu,
      input logic [1:0] pm, input logic [3:0] dv, input logic [3:0] f);
      return {4'h0, f, 1'b0, mu, 9'h0, pm, 4'h0, dv};
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Hang guard, far above the roughly 800 cycles needed
   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         mismatches++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rd(`CLW_OFS_CTRL, v);
      chk(v, ctl(4'h2, 2'h0, 4'h3, 4'h4));
      rd(5'h14, v);
      chk(v, 32'h0);
      foreach (rows[i])
      begin
         r = rows[i];
         @(posedge mclk_i) freeze_i <= 1'b1;
         wr(`CLW_OFS_LOCK, 32'(r[22:20]));
         @(posedge mclk_i) freeze_i <= 1'b0;
         wr(`CLW_OFS_CTRL, ctl(r[19:16], r[15:14], r[13:10], 4'hc));
         cyc(1);
         chk(32'({mult, pmode, div}), 32'(r[9:0]));
         chk(32'(src), 32'h1);
      end
      wr(`CLW_OFS_LOCK, 32'h0);
      wr(5'h14, 32'hffffffff);
      rd(`CLW_OFS_LOCK, v);
      chk(32'(v[2:0]), 32'h7);
      rd(`CLW_OFS_CTRL, v);
      chk(v, ctl(4'h6, 2'h1, 4'h4, 4'hc));
      wr(`CLW_OFS_LOCK, 32'h0f);
      cyc(1);
      chk(32'(wake), 32'h1);
      @(posedge mclk_i) rstn_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rd(`CLW_OFS_LOCK, v);
      chk(32'({wake, v[3:0]}), 32'h18);
      wr(`CLW_OFS_LOCK, 32'h0);
      cyc(1);
      chk(32'(wake), 32'h0);
      $display("test locks and wake done");
      wr(`CLW_OFS_CTRL, ctl(4'h2, 2'h0, 4'h3, 4'hc));
      for (int m = 1; m >= 0; m--)
      begin
         @(posedge mclk_i) external_interrupt_enable_i <= m[0];
         wr(`CLW_OFS_LOCK, 32'h0);
         wr(`CLW_OFS_DEC, 32'h1);
         hit = 1'b0;
         repeat (16)
         begin
            @(negedge mclk_i);
            hit |= (irq === 1'b1);
         end
         chk(32'(hit), 32'(m));
         chk(32'(wake), 32'h1);
      end
      wr(`CLW_OFS_TB_LO, 32'h0);
      wr(`CLW_OFS_TB_HI, 32'h0);
      cyc(40);
      rd(`CLW_OFS_TB_LO, v);
      chk(32'(v >= 10 && v <= 11), 32'h1);
      wr(`CLW_OFS_TB_LO, 32'hffffffff);
      cyc(8);
      rd(`CLW_OFS_TB_HI, v);
      chk(v, 32'h1);
      wr(`CLW_OFS_CTRL, ctl(4'h2, 2'h0, 4'h3, 4'h4));
      wr(`CLW_OFS_TB_LO, 32'h0);
      cyc(400);
      rd(`CLW_OFS_TB_LO, v);
      chk(32'(v >= 11 && v <= 13), 32'h1);
      for (int k = 0; k < 3; k++)
      begin
         @(posedge mclk_i) freeze_i <= (k == 0);
         freeze_counter_enable_i <= 1'b1;
         wr(`CLW_OFS_CTRL, ctl(4'h2, k == 1 ? 2'h3 : 2'h0, 4'h3,
            k == 2 ? 4'h8 : 4'hc));
         cyc(8);
         rd(k == 2 ? `CLW_OFS_DEC : `CLW_OFS_TB_LO, v);
         cyc(20);
         rd(k == 2 ? `CLW_OFS_DEC : `CLW_OFS_TB_LO, w);
         chk(w, v);
      end
      $display("test counters done");
      wr(`CLW_OFS_LOCK, 32'h20);
      rd(`CLW_OFS_LOCK, v);
      chk(32'(v[5:4]), 32'h3);
      for (int j = 0; j < 4; j++)
      begin
         // Enables only set while bypass is off
         wr(`CLW_OFS_CTRL, ctl(4'h5, 2'h0, 4'h3, fsel[j]));
         @(posedge mclk_i) drop <= 2'h1 << j[0];
         hit = 1'b0;
         repeat (8)
         begin
            @(negedge mclk_i);
            hit |= (crst === 1'b1);
         end
         chk(32'(hit), 32'(j[1]));
         rd(`CLW_OFS_LOCK, v);
         if (j < 2)
            chk(32'({selfclk, v[6:4]}), j[0] ? 32'hc : 32'h0);
         @(posedge mclk_i) pll_bypass_i <= (j == 0);
         rd(`CLW_OFS_LOCK, v);
         chk(32'(v[4]), 32'(j == 0));
         @(posedge mclk_i) pll_bypass_i <= 1'b0;
         drop <= 2'h0;
         cyc(8);
         chk(32'({crst, mult}), j[1] ? 32'h2 : 32'h5);
      end
      @(posedge mclk_i) special_test_i <= 1'b1;
      wr(`CLW_OFS_LOCK, 32'h40);
      rd(`CLW_OFS_LOCK, v);
      chk(32'({selfclk, v[6:4]}), 32'hc);
      wr(`CLW_OFS_LOCK, 32'h0);
      rd(`CLW_OFS_LOCK, v);
      chk(32'({selfclk, v[6:4]}), 32'h1);
      @(posedge mclk_i) special_test_i <= 1'b0;
      $display("test clock reset done");
      complete_run();
   end
endmodule
`default_nettype wire
